// ### src/motion_sequence_control.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// R1: action 0 holds end setpoint until abort
// R2: action 1 stops motor, sequencer keeps setpoint
// R3: action 2 stops, returns at standstill
// R4: far side issues new start after return
// R5: action 3 returns without stopping motor
// R6: complete only after all steps and cycles
// R7: restart policy applies after stop or error
// R8: policy 0 restarts sequence from first segment
// R9: policy 1 restarts active segment from beginning
// R10: policy 2 resumes segment where interrupted
// R11: policy 3 skips to the following segment
// R12: policy 4 keeps processing while motor stopped
// R13: four select bits form binary sequence number
// R14: zero means none, nine to fifteen invalid
// R15: never start without a start function
// R16: level start runs while trigger held
// R17: separate edge start starts selected sequence
// R18: level trigger false aborts, restores setpoint
// R19: rising edge starts, falling edge ignored
// R20: restart policy resets to zero
// R21: sample select at start, reject zero/invalid
module motion_sequence_control
  import seq_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = SEG_TICK_CYCLES,
  parameter int DUR_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [seq_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [seq_ctrl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [seq_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [seq_ctrl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic seq_select_bit0,
  input wire logic seq_select_bit1,
  input wire logic seq_select_bit2,
  input wire logic seq_select_bit3,
  input wire logic level_run_trigger,
  input wire logic edge_start_trigger,
  input wire logic abort_trigger,
  input wire logic motor_running,
  input wire logic motor_standstill,
  output logic seq_setpoint_ctrl,
  output logic seq_end_segment,
  output logic [3:0] seq_number,
  output logic [2:0] seq_segment,
  output logic motor_stop_req,
  output logic [7:0] stop_method_select
);
  import seq_ctrl_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  seq_state_e state_reg;
  logic [7:0] restart_policy_select_reg;
  logic [7:0] completion_action_select_reg;
  logic [7:0] stop_method_reg;
  logic [2:0] last_seg_reg;
  logic [7:0] cycles_reg;
  logic [2:0] seq_reg;
  logic [2:0] seg_reg;
  logic [7:0] cycle_reg;
  logic [DUR_W-1:0] seg_time_reg;
  logic [31:0] tick_cnt_reg;
  logic fresh_reg;
  logic by_level_reg;
  logic end_stop_reg;
  logic level_prev_reg;
  logic edge_prev_reg;
  logic stop_req_reg;
  logic [DUR_W-1:0] dur_q;
  logic [DUR_W-1:0] bus_tab_q;
  logic [3:0] sel_value;
  logic sel_none;
  logic sel_invalid;
  logic level_rise;
  logic edge_rise;
  logic tick;
  logic active;
  logic abort_ev;
  logic start_ev;
  logic elapsed;
  logic elapsed_ev;
  logic pause_ev;
  logic resume_ev;
  logic advance_ev;
  logic complete_ev;
  logic seg_restart;
  logic last_seg;
  logic [7:0] eff_cycles;
  logic [7:0] cycle_inc;
  logic [7:0] eff_policy;
  seq_state_e done_state;

  // ****************************************************************
  // trigger decode
  // ****************************************************************
  assign sel_value = {seq_select_bit3, seq_select_bit2,
                      seq_select_bit1, seq_select_bit0}; // R13
  assign sel_none = (sel_value == 4'h0); // R14
  assign sel_invalid = (sel_value > 4'h8); // R14
  assign level_rise = level_run_trigger & ~level_prev_reg; // R16
  // a falling edge of the edge trigger never does anything
  assign edge_rise = edge_start_trigger & ~edge_prev_reg; // R19

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      level_prev_reg <= 1'b0;
      edge_prev_reg <= 1'b0;
    end else begin
      level_prev_reg <= level_run_trigger;
      edge_prev_reg <= edge_start_trigger;
    end
  end

  // ****************************************************************
  // sequence events
  // ****************************************************************
  // policy codes above 4 fall back to a full restart
  assign eff_policy = (restart_policy_select_reg > RP_NO_ACTION) ?
                      RP_RESTART_SEQ : restart_policy_select_reg;
  assign eff_cycles = (cycles_reg == 8'h00) ? 8'h01 : cycles_reg;
  assign cycle_inc = cycle_reg + 8'h01;
  assign last_seg = (seg_reg == last_seg_reg);
  assign active = (state_reg != ST_IDLE);
  assign abort_ev = active &
                    (abort_trigger | (by_level_reg & ~level_run_trigger)); // R18
  assign start_ev = (state_reg == ST_IDLE) & (level_rise | edge_rise) &
                    ~sel_none & ~sel_invalid & ~abort_trigger; // R15 R17 R21
  // dur_q lags a segment change by one cycle, so skip that cycle
  assign elapsed = ~fresh_reg & (seg_time_reg >= dur_q);
  assign elapsed_ev = (state_reg == ST_RUN) & elapsed;
  assign pause_ev = (state_reg == ST_RUN) & ~motor_running &
                    (eff_policy != RP_NO_ACTION); // R7 R12
  assign resume_ev = (state_reg == ST_HOLD) & motor_running; // R7
  assign advance_ev = elapsed_ev |
                      (resume_ev & (eff_policy == RP_NEXT_SEG)); // R11
  assign complete_ev = advance_ev & last_seg & (cycle_inc >= eff_cycles); // R6
  assign seg_restart = start_ev | advance_ev |
                       (resume_ev & (eff_policy == RP_RESTART_SEQ)) |
                       (resume_ev & (eff_policy == RP_RESTART_SEG)); // R9

  always_comb begin
    unique case (completion_action_select_reg)
      CA_STOP: done_state = ST_END; // R2
      CA_STOP_ABORT: done_state = ST_STOP; // R3
      CA_ABORT: done_state = ST_IDLE; // R5
      default: done_state = ST_END; // R1
    endcase
  end

  // ****************************************************************
  // state machine
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else if (abort_ev) begin
      state_reg <= ST_IDLE; // R18
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_ev) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (complete_ev) begin
            state_reg <= done_state; // R6
          end else if (pause_ev) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (complete_ev) begin
            state_reg <= done_state;
          end else if (resume_ev) begin
            state_reg <= ST_RUN;
          end
        end
        ST_END: begin
          state_reg <= ST_END; // R1 R2
        end
        ST_STOP: begin
          if (motor_standstill) begin
            state_reg <= ST_IDLE; // R3
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      by_level_reg <= 1'b0;
      seq_reg <= 3'h0;
      end_stop_reg <= 1'b0;
    end else begin
      if (start_ev) begin
        by_level_reg <= level_rise;
        seq_reg <= 3'(sel_value - 4'h1); // R21
      end
      if (complete_ev) begin
        end_stop_reg <= (completion_action_select_reg == CA_STOP); // R2
      end
    end
  end

  // ****************************************************************
  // segment position and timing
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seg_reg <= 3'h0;
      cycle_reg <= 8'h00;
    end else if (start_ev || (resume_ev && eff_policy == RP_RESTART_SEQ)) begin
      seg_reg <= 3'h0; // R8
      cycle_reg <= 8'h00;
    end else if (advance_ev && !complete_ev) begin
      seg_reg <= last_seg ? 3'h0 : seg_reg + 3'h1;
      cycle_reg <= last_seg ? cycle_inc : cycle_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // time stands still in HOLD, so policy 2 resumes where it left off
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      seg_time_reg <= '0;
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= seg_restart;
      if (seg_restart) begin
        seg_time_reg <= '0; // R9
      end else if (state_reg == ST_RUN && tick && !elapsed) begin
        seg_time_reg <= seg_time_reg + 1'b1; // R10 R12
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stop_req_reg <= 1'b0;
    end else begin
      stop_req_reg <= ~abort_ev &
                      (((state_reg == ST_END) & end_stop_reg) |
                       (state_reg == ST_STOP)); // R2 R3
    end
  end

  assign motor_stop_req = stop_req_reg;
  assign seq_setpoint_ctrl = active; // R1
  assign seq_end_segment = state_reg[3] | state_reg[4];
  assign seq_number = active ? {1'b0, seq_reg} + 4'h1 : 4'h0;
  assign seq_segment = seg_reg;
  assign stop_method_select = stop_method_reg;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rd_pend_reg;
  logic [ADDR_W-1:0] ar_addr_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic wr_tab;
  logic rd_tab;
  logic wr_hit;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;

  assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
  assign s_axi_arready = ~rd_pend_reg & ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign do_write = aw_full_reg & w_full_reg;
  assign wr_tab = (aw_addr_reg[15:8] == TABLE_PAGE) &&
                  (aw_addr_reg[1:0] == 2'b00);
  assign wr_hit = wr_tab || aw_addr_reg == RESTART_POLICY_OFS ||
                  aw_addr_reg == COMPLETION_ACTION_OFS ||
                  aw_addr_reg == STOP_METHOD_OFS ||
                  aw_addr_reg == SEQ_CONFIG_OFS ||
                  aw_addr_reg == STATUS_OFS;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // a status write is accepted but changes nothing
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      restart_policy_select_reg <= RESTART_POLICY_RST; // R20
      completion_action_select_reg <= COMPLETION_ACTION_RST;
      stop_method_reg <= STOP_METHOD_RST;
      last_seg_reg <= LAST_SEG_RST;
      cycles_reg <= CYCLES_RST;
    end else if (do_write) begin
      if (w_strb_reg[0]) begin
        unique case (aw_addr_reg)
          RESTART_POLICY_OFS: restart_policy_select_reg <= w_data_reg[7:0];
          COMPLETION_ACTION_OFS:
            completion_action_select_reg <= w_data_reg[7:0];
          STOP_METHOD_OFS: stop_method_reg <= w_data_reg[7:0];
          SEQ_CONFIG_OFS:
            last_seg_reg <= w_data_reg[CFG_LAST_SEG_LSB +: 3];
          default: ;
        endcase
      end
      if (w_strb_reg[1] && aw_addr_reg == SEQ_CONFIG_OFS) begin
        cycles_reg <= w_data_reg[CFG_CYCLES_LSB +: 8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rd_pend_reg <= 1'b0;
      ar_addr_reg <= '0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_reg <= 1'b1;
        ar_addr_reg <= s_axi_araddr;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign rd_tab = (ar_addr_reg[15:8] == TABLE_PAGE) &&
                  (ar_addr_reg[1:0] == 2'b00);

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (rd_tab) begin
      rd_word[DUR_W-1:0] = bus_tab_q;
    end else begin
      unique case (ar_addr_reg)
        RESTART_POLICY_OFS: rd_word[7:0] = restart_policy_select_reg;
        COMPLETION_ACTION_OFS: rd_word[7:0] = completion_action_select_reg;
        STOP_METHOD_OFS: rd_word[7:0] = stop_method_reg;
        SEQ_CONFIG_OFS: begin
          rd_word[CFG_LAST_SEG_LSB +: 3] = last_seg_reg;
          rd_word[CFG_CYCLES_LSB +: 8] = cycles_reg;
        end
        STATUS_OFS: begin
          rd_word[ST_STATE_LSB +: 5] = state_reg;
          rd_word[ST_SEQ_LSB +: 3] = seq_reg;
          rd_word[ST_SEG_LSB +: 3] = seg_reg;
          rd_word[ST_CYCLE_LSB +: 8] = cycle_reg;
          rd_word[ST_INVALID_BIT] = sel_invalid;
          rd_word[ST_NONE_BIT] = sel_none;
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // segment time table
  // ****************************************************************
  seg_time_mem #(
    .AW(6),
    .DW(DUR_W)
  ) u_seg_time_mem (
    .core_clk(core_clk),
    .nrst(nrst),
    .we(do_write && wr_tab && (w_strb_reg[1:0] == 2'b11)),
    .waddr(aw_addr_reg[7:2]),
    .wdata(w_data_reg[DUR_W-1:0]),
    .raddr_a({seq_reg, seg_reg}),
    .rdata_a(dur_q),
    .raddr_b(s_axi_araddr[7:2]),
    .rdata_b(bus_tab_q)
  );

endmodule

// ### src/seq_ctrl_pkg.sv
package seq_ctrl_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [15:0] RESTART_POLICY_OFS = 16'h4040;
  localparam logic [15:0] COMPLETION_ACTION_OFS = 16'h4044;
  localparam logic [15:0] STOP_METHOD_OFS = 16'h4048;
  localparam logic [15:0] SEQ_CONFIG_OFS = 16'h404C;
  localparam logic [15:0] STATUS_OFS = 16'h4050;
  localparam logic [7:0] TABLE_PAGE = 8'h41;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CFG_LAST_SEG_LSB = 0;
  localparam int CFG_CYCLES_LSB = 8;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_SEQ_LSB = 8;
  localparam int ST_SEG_LSB = 16;
  localparam int ST_CYCLE_LSB = 20;
  localparam int ST_INVALID_BIT = 28;
  localparam int ST_NONE_BIT = 29;
  localparam logic [7:0] RESTART_POLICY_RST = 8'h00;
  localparam logic [7:0] COMPLETION_ACTION_RST = 8'h00;
  localparam logic [7:0] STOP_METHOD_RST = 8'h00;
  localparam logic [2:0] LAST_SEG_RST = 3'h3;
  localparam logic [7:0] CYCLES_RST = 8'h01;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [7:0] CA_KEEP_RUNNING = 8'h00;
  localparam logic [7:0] CA_STOP = 8'h01;
  localparam logic [7:0] CA_STOP_ABORT = 8'h02;
  localparam logic [7:0] CA_ABORT = 8'h03;
  localparam logic [7:0] RP_RESTART_SEQ = 8'h00;
  localparam logic [7:0] RP_RESTART_SEG = 8'h01;
  localparam logic [7:0] RP_CONTINUE_SEG = 8'h02;
  localparam logic [7:0] RP_NEXT_SEG = 8'h03;
  localparam logic [7:0] RP_NO_ACTION = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // timing: one segment time unit
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SEG_TICK_NS = 1000000;
  localparam int SEG_TICK_CYCLES = SEG_TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RUN = 5'b00010,
    ST_HOLD = 5'b00100,
    ST_END = 5'b01000,
    ST_STOP = 5'b10000
  } seq_state_e;

endpackage

// ### src/seg_time_mem.sv
`timescale 1ns/1ps
module seg_time_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [DW-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_b
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // two registered read ports: one for the sequencer, one for the bus
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end

endmodule

// ### tb/msc_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// port-level checks of the sequencer control
// ****************************************************************
module msc_assertions (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic seq_select_bit0,
  input wire logic seq_select_bit1,
  input wire logic seq_select_bit2,
  input wire logic seq_select_bit3,
  input wire logic level_run_trigger,
  input wire logic edge_start_trigger,
  input wire logic abort_trigger,
  input wire logic seq_setpoint_ctrl,
  input wire logic seq_end_segment,
  input wire logic [3:0] seq_number,
  input wire logic motor_stop_req,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  wire [3:0] sel = {seq_select_bit3, seq_select_bit2, seq_select_bit1,
    seq_select_bit0};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_start_edge:
  assert property ($rose(seq_setpoint_ctrl) |->
    ($past(level_run_trigger) && !$past(level_run_trigger, 2)) ||
    ($past(edge_start_trigger) && !$past(edge_start_trigger, 2)))
    else $error("sequence started without a trigger edge");
  chk_sel_sampled:
  assert property ($rose(seq_setpoint_ctrl) |-> seq_number == $past(sel) &&
    $past(sel) inside {[4'h1:4'h8]})
    else $error("sequence number differs from sampled select");
  chk_abort_wins:
  assert property (abort_trigger |=> !seq_setpoint_ctrl)
    else $error("abort did not return setpoint control");
  chk_idle_number:
  assert property (!seq_setpoint_ctrl |-> seq_number == 4'h0)
    else $error("sequence number shown while idle");
  chk_number_hold:
  assert property (seq_setpoint_ctrl && $past(seq_setpoint_ctrl) |->
    $stable(seq_number))
    else $error("sequence number changed while active");
  chk_stop_owner:
  assert property (motor_stop_req |-> $past(seq_end_segment))
    else $error("stop request outside the end segment");
  chk_bresp_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_rdata_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule

bind motion_sequence_control msc_assertions u_chk (.core_clk, .nrst,
  .seq_select_bit0, .seq_select_bit1, .seq_select_bit2, .seq_select_bit3,
  .level_run_trigger, .edge_start_trigger, .abort_trigger,
  .seq_setpoint_ctrl, .seq_end_segment, .seq_number, .motor_stop_req,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata);

// ### tb/motor_model.sv
`timescale 1ns/1ps
// ****************************************************************
// motor control stand-in
// ****************************************************************
module motor_model #(
  parameter int DECEL = 3
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic run_cmd,
  input wire logic motor_stop_req,
  output logic motor_running,
  output logic motor_standstill
);
  logic cmd_q, held;
  int slow;
  // a sequencer stop sticks until a fresh run command edge
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cmd_q <= 1'b0;
      held <= 1'b0;
      motor_running <= 1'b0;
      slow <= 0;
    end else begin
      cmd_q <= run_cmd;
      if (motor_stop_req) held <= 1'b1;
      else if (run_cmd && !cmd_q) held <= 1'b0;
      motor_running <= run_cmd && !held && !motor_stop_req;
      slow <= motor_running ? DECEL : (slow > 0 ? slow - 1 : 0);
    end
  end
  assign motor_standstill = !motor_running && slow == 0;
endmodule

// ### tb/motion_sequence_control_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// self-checking bench
// ****************************************************************
module motion_sequence_control_tb;
  import seq_ctrl_pkg::*;
  localparam int TK = 4;
  localparam logic [3:0] CAX [4] = '{4'hD, 4'hE, 4'h0, 4'h1};
  localparam logic [2:0] RPX [5] = '{0, 1, 1, 2, 2};
  logic core_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, motor_stop_req;
  logic level_run_trigger, edge_start_trigger, abort_trigger, run_cmd;
  logic motor_running, motor_standstill, seq_setpoint_ctrl, seq_end_segment;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] sel, seq_number;
  logic [2:0] seq_segment;
  logic [7:0] stop_method_select;
  int error_cnt, n_checks, k, g, n, e;
  int dur [4];

  motion_sequence_control #(.TICK_CYCLES(TK)) uut (.core_clk, .nrst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .seq_select_bit0(sel[0]), .seq_select_bit1(sel[1]),
    .seq_select_bit2(sel[2]), .seq_select_bit3(sel[3]), .level_run_trigger,
    .edge_start_trigger, .abort_trigger, .motor_running, .motor_standstill,
    .seq_setpoint_ctrl, .seq_end_segment, .seq_number, .seq_segment,
    .motor_stop_req, .stop_method_select);
  motor_model u_motor (.core_clk, .nrst, .run_cmd, .motor_stop_req,
    .motor_running, .motor_standstill);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ready follows valid by a cycle so the hold checks get exercised
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int t = 0; t < 40; t++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    check(s_axi_bvalid && s_axi_bready, 1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int t = 0; t < 40; t++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    check(s_axi_rvalid && s_axi_rready, 1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [15:0] ta(input int q, input int s);
    return 16'h4100 + 16'(4 * ((q - 1) * 8 + s));
  endfunction

  task automatic go(input logic [3:0] s);
    sel <= s;
    edge_start_trigger <= 1'b1;
    cyc(2);
  endtask

  task automatic halt;
    abort_trigger <= 1'b1;
    cyc(1);
    abort_trigger <= 1'b0;
    edge_start_trigger <= 1'b0;
    run_cmd <= 1'b0;
    cyc(1);
    run_cmd <= 1'b1;
    cyc(3);
  endtask

  initial begin
    void'($urandom(32'hD7CC7324));
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, abort_trigger, level_run_trigger, edge_start_trigger} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sel} = '0;
    run_cmd = 1'b1;
    cyc(10);
    nrst <= 1'b1;
    cyc(1);
    rd(RESTART_POLICY_OFS);
    check(d, 0);
    rd(16'h4000);
    check({d, r}, {32'h0, RESP_SLVERR});
    wr(16'h4000, 32'hFF);
    check(r, RESP_SLVERR);
    wr(STOP_METHOD_OFS, 32'h2);
    check(stop_method_select, 8'h2);
    for (k = 1; k < 9; k++) for (g = 0; g < 4; g++) begin
      e = $urandom_range(3, 6);
      if (k == 1) dur[g] = e;
      wr(ta(k, g), e);
    end
    $display("register test done");
    cyc(20);
    check(seq_setpoint_ctrl, 0);
    for (k = 0; k < 16; k++) begin
      go(4'(k));
      check(seq_setpoint_ctrl, k >= 1 && k <= 8);
      check(seq_number, (k >= 1 && k <= 8) ? k : 0);
      halt();
      check(seq_setpoint_ctrl, 0);
    end
    $display("select test done");
    wr(SEQ_CONFIG_OFS, 32'h0203);
    for (k = 0; k < 4; k++) begin
      wr(COMPLETION_ACTION_OFS, k);
      e = 2 * TK * (dur[0] + dur[1] + dur[2] + dur[3]);
      go(4'h1);
      for (n = 2; !seq_end_segment && seq_setpoint_ctrl && n < 400; n++) begin
        cyc(1);
      end
      check(n >= e - 12 && n <= e + 12, 1);
      cyc(20);
      check({seq_setpoint_ctrl, seq_end_segment, motor_stop_req,
        motor_running}, CAX[k]);
      halt();
      check(motor_running, 1);
    end
    $display("completion test done");
    wr(COMPLETION_ACTION_OFS, 0);
    for (g = 0; g < 4; g++) wr(ta(2, g), 6);
    for (k = 0; k < 5; k++) begin
      wr(RESTART_POLICY_OFS, k);
      go(4'h2);
      for (n = 0; seq_segment != 1 && n < 200; n++) begin
        cyc(1);
      end
      cyc(12);
      run_cmd <= 1'b0;
      cyc(16);
      check(seq_segment, (k == 4) ? 2 : 1);
      run_cmd <= 1'b1;
      cyc(3);
      check(seq_segment, RPX[k]);
      for (n = 0; seq_segment != 2 && n < 200; n++) begin
        cyc(1);
      end
      check({n >= 18, n < 200}, {k < 2, 1'b1});
      halt();
    end
    $display("restart test done");
    sel <= 4'h3;
    level_run_trigger <= 1'b1;
    cyc(60);
    check(seq_setpoint_ctrl, 1);
    level_run_trigger <= 1'b0;
    cyc(2);
    check(seq_setpoint_ctrl, 0);
    $display("level test done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
endmodule
